//--- rtl/dcas_top.sv
// dcas_top: register file and controller-wide status of a four-channel dma.
// assumes an external transfer engine reporting transfers, block ends and
// collisions as one-cycle pulses synchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// RULE_01: each channel keeps a 16-bit first buffer base, reset zero.
// RULE_02: each channel keeps a 16-bit second buffer base, reset zero.
// RULE_03: each channel keeps a 16-bit read/write peripheral pointer, reset zero.
// RULE_04: software must not rewrite pointer or tally while the channel runs.
// RULE_05: 10-bit transfer tally, upper bits zero; a block is tally plus one.
// RULE_06: per-channel peripheral write clash flags in bits 8 to 11.
// RULE_07: per-channel ram write clash flags in bits 0 to 3.
// RULE_08: last active channel field bits 11-8 reads all ones after reset.
// RULE_09: each transfer loads the channel number 0 to 3 into that field.
// RULE_10: per-channel toggle bit reads one while second base is selected.
// RULE_11: read-only latest ram pointer holds the last ram address touched.
// RULE_12: unimplemented status bits 15-12 and 7-4 read zero.
// RULE_13: clash flags stay set until written zero; writing one does nothing.
// RULE_14: four identical channels numbered 0 to 3.
// RULE_15: a channel transfers only while its channel_on bit 15 is one.
// RULE_16: two-bit mode picks continuous, one-shot and their ping-pong forms.
module dcas_top import dcas_pkg::*; (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // transfer engine events
  input wire logic xfer_done,
  input wire dcas_xfer_type xfer_info,
  input wire logic [NUM_CHAN-1:0] block_done,
  input wire logic [NUM_CHAN-1:0] periph_write_clash_evt,
  input wire logic [NUM_CHAN-1:0] ram_write_clash_evt,
  // channel settings to the engine
  output dcas_chan_type [NUM_CHAN-1:0] chan_cfg,
  output logic [NUM_CHAN-1:0][15:0] current_buffer_base
);

  typedef struct packed {
    logic [3:0] periph_write_clash;
    logic [3:0] ram_write_clash;
    logic [3:0] last_active_channel;
    logic [15:0] latest_ram_pointer;
    logic ack;
    logic [DATA_W-1:0] rdata;
  } dcas_state_type;

  dcas_state_type st_reg;
  dcas_state_type st_next;

  logic [1:0] lanes;
  logic wr_take;
  logic chan_hit;
  logic [1:0] chan_idx;
  logic [2:0] chan_sel;
  logic xfer_ok;
  logic [15:0] rd_word;
  logic [15:0] clash_word;
  logic [15:0] history_word;
  logic [3:0] clear_mask;
  logic [3:0] toggles;

  // only the low half carries register data
  assign lanes = avs_byteenable[1:0];
  // a write lands at the edge where waitrequest is seen low
  assign wr_take = avs_write && st_reg.ack;
  assign chan_idx = avs_address[4:3];
  assign chan_sel = avs_address[2:0];
  assign chan_hit = (avs_address < (CHAN_SPAN * 6'h04)) && (chan_sel <= SEL_TALLY); // see RULE_14

  // four identical channels
  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g = g + 1) begin : gen_chan
      dcas_channel u_chan (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .wr_en(wr_take && chan_hit && (chan_idx == 2'(g))), // see RULE_14
        .wr_sel(chan_sel),
        .wr_data(avs_writedata[15:0]),
        .wr_lanes(lanes),
        .block_done(block_done[g]),
        .cfg(chan_cfg[g])
      );
      assign toggles[g] = chan_cfg[g].buffer_toggle_state;
      assign current_buffer_base[g] = chan_cfg[g].buffer_toggle_state ?
        chan_cfg[g].second_buffer_base : chan_cfg[g].first_buffer_base; // see RULE_10
    end
  endgenerate

  // a transfer counts only for a channel that is switched on
  assign xfer_ok = xfer_done && chan_cfg[xfer_info.chan].channel_on; // see RULE_15

  assign clash_word = {4'h0, st_reg.periph_write_clash,
                       4'h0, st_reg.ram_write_clash}; // see RULE_12
  assign history_word = {4'h0, st_reg.last_active_channel,
                         4'h0, toggles}; // see RULE_12

  // read decode
  always_comb begin
    rd_word = 16'h0000;
    if (chan_hit) begin
      if (chan_sel == SEL_CTRL) begin
        rd_word = dcas_ctrl_word(chan_cfg[chan_idx]);
      end else if (chan_sel == SEL_FIRST) begin
        rd_word = chan_cfg[chan_idx].first_buffer_base;
      end else if (chan_sel == SEL_SECOND) begin
        rd_word = chan_cfg[chan_idx].second_buffer_base;
      end else if (chan_sel == SEL_PERIPH) begin
        rd_word = chan_cfg[chan_idx].periph_pointer; // see RULE_03
      end else begin
        rd_word = {6'h00, chan_cfg[chan_idx].transfer_tally}; // see RULE_05
      end
    end else if (avs_address == ADDR_CLASH) begin
      rd_word = clash_word;
    end else if (avs_address == ADDR_HISTORY) begin
      rd_word = history_word;
    end else if (avs_address == ADDR_LATEST) begin
      rd_word = st_reg.latest_ram_pointer; // see RULE_11
    end else begin
      rd_word = 16'h0000;
    end
  end

  always_comb begin
    st_next = st_reg;
    clear_mask = 4'h0;
    // one wait state: request seen, then answered from registered data
    st_next.ack = (avs_read || avs_write) && !st_reg.ack;
    if (avs_read && !st_reg.ack) begin
      st_next.rdata = {16'h0000, rd_word};
    end
    // clash flags: zero clears, one is ignored, a new event wins
    if (wr_take && (avs_address == ADDR_CLASH)) begin
      if (lanes[1]) begin
        st_next.periph_write_clash = st_reg.periph_write_clash &
          avs_writedata[PCLASH_LSB +: 4]; // see RULE_13
      end
      if (lanes[0]) begin
        st_next.ram_write_clash = st_reg.ram_write_clash &
          avs_writedata[RCLASH_LSB +: 4]; // see RULE_13
      end
    end
    st_next.periph_write_clash = st_next.periph_write_clash | periph_write_clash_evt; // see RULE_06
    st_next.ram_write_clash = st_next.ram_write_clash | ram_write_clash_evt; // see RULE_07
    // reserved codes 4 to 14 cannot arise: only a two-bit channel is loaded
    if (xfer_ok) begin
      st_next.last_active_channel = {2'b00, xfer_info.chan}; // see RULE_09
      st_next.latest_ram_pointer = xfer_info.ram_addr; // see RULE_11
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{periph_write_clash: FLAGS_RST, ram_write_clash: FLAGS_RST,
                  last_active_channel: LASTCH_RST, // see RULE_08
                  latest_ram_pointer: ADDR_RST, ack: 1'b0,
                  rdata: 32'h0000_0000};
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign avs_waitrequest = !st_reg.ack;
  assign avs_readdata = st_reg.rdata;

endmodule // dcas_top
`default_nettype wire

//--- rtl/dcas_pkg.sv
// dcas_pkg: constants, register map and carrier types for the dma channel
// address and status block.
// assumes a 16-bit register view placed in the low half of a 32-bit avalon word.
package dcas_pkg;

  localparam int NUM_CHAN = 4;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;

  // avalon word indexes; byte address is four times the index
  localparam logic [ADDR_W-1:0] CHAN_SPAN = 6'h08;
  localparam logic [ADDR_W-1:0] ADDR_CLASH = 6'h20;
  localparam logic [ADDR_W-1:0] ADDR_HISTORY = 6'h21;
  localparam logic [ADDR_W-1:0] ADDR_LATEST = 6'h22;

  // per-channel register select, low three bits of the word index
  localparam logic [2:0] SEL_CTRL = 3'h0;
  localparam logic [2:0] SEL_FIRST = 3'h1;
  localparam logic [2:0] SEL_SECOND = 3'h2;
  localparam logic [2:0] SEL_PERIPH = 3'h3;
  localparam logic [2:0] SEL_TALLY = 3'h4;

  // control word field positions and tally width
  localparam int CTRL_ON_BIT = 15;
  localparam int CTRL_DIR_BIT = 13;
  localparam int TALLY_W = 10;

  // field positions in the status words
  localparam int PCLASH_LSB = 8;
  localparam int RCLASH_LSB = 0;
  localparam int LASTCH_LSB = 8;
  localparam int TOGGLE_LSB = 0;

  // reset values
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [TALLY_W-1:0] TALLY_RST = 10'h000;
  localparam logic [3:0] LASTCH_RST = 4'hf;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  typedef enum logic [1:0] {
    MODE_CONT = 2'b00,
    MODE_ONESHOT = 2'b01,
    MODE_CONT_PP = 2'b10,
    MODE_ONESHOT_PP = 2'b11
  } dcas_mode_type;

  typedef struct packed {
    logic channel_on;
    logic dir;
    dcas_mode_type mode;
    logic [15:0] first_buffer_base;
    logic [15:0] second_buffer_base;
    logic [15:0] periph_pointer;
    logic [TALLY_W-1:0] transfer_tally;
    logic buffer_toggle_state;
  } dcas_chan_type;

  typedef struct packed {
    logic [1:0] chan;
    logic [15:0] ram_addr;
  } dcas_xfer_type;

  // byte-lane merge of a 16-bit register write
  function automatic logic [15:0] dcas_merge(input logic [15:0] old_val,
                                             input logic [15:0] new_val,
                                             input logic [1:0] lanes);
    dcas_merge = {lanes[1] ? new_val[15:8] : old_val[15:8],
                  lanes[0] ? new_val[7:0] : old_val[7:0]};
  endfunction

  function automatic logic [15:0] dcas_ctrl_word(input dcas_chan_type c);
    dcas_ctrl_word = 16'h0000;
    dcas_ctrl_word[CTRL_ON_BIT] = c.channel_on;
    dcas_ctrl_word[CTRL_DIR_BIT] = c.dir;
    dcas_ctrl_word[1:0] = c.mode;
  endfunction

endpackage

//--- rtl/dcas_channel.sv
// dcas_channel: one channel's control, buffer bases, pointer and tally.
// assumes writes arrive already decoded and byte-lane qualified.
`timescale 1ns/100ps
`default_nettype none
module dcas_channel import dcas_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // register write
  input wire logic wr_en,
  input wire logic [2:0] wr_sel,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] wr_lanes,
  // engine event
  input wire logic block_done,
  // state
  output dcas_chan_type cfg
);

  dcas_chan_type st_reg;
  dcas_chan_type st_next;
  logic [15:0] ctrl_new;
  logic [15:0] tally_new;

  always_comb begin
    st_next = st_reg;
    ctrl_new = dcas_merge(dcas_ctrl_word(st_reg), wr_data, wr_lanes);
    tally_new = dcas_merge({6'h00, st_reg.transfer_tally}, wr_data, wr_lanes);
    if (wr_en) begin
      case (wr_sel)
        SEL_CTRL: begin
          st_next.channel_on = ctrl_new[CTRL_ON_BIT]; // see RULE_15
          st_next.dir = ctrl_new[CTRL_DIR_BIT];
          st_next.mode = dcas_mode_type'(ctrl_new[1:0]); // see RULE_16
        end
        SEL_FIRST: st_next.first_buffer_base =
          dcas_merge(st_reg.first_buffer_base, wr_data, wr_lanes); // see RULE_01
        SEL_SECOND: st_next.second_buffer_base =
          dcas_merge(st_reg.second_buffer_base, wr_data, wr_lanes); // see RULE_02
        SEL_PERIPH: st_next.periph_pointer =
          dcas_merge(st_reg.periph_pointer, wr_data, wr_lanes); // see RULE_03
        SEL_TALLY: st_next.transfer_tally = tally_new[TALLY_W-1:0]; // see RULE_05
        default: st_next = st_reg;
      endcase
    end
    // the engine's block end wins over a same-cycle software write
    if (block_done && st_reg.channel_on) begin
      case (st_reg.mode)
        MODE_ONESHOT: st_next.channel_on = 1'b0; // see RULE_16
        MODE_CONT_PP: st_next.buffer_toggle_state = ~st_reg.buffer_toggle_state; // see RULE_10
        MODE_ONESHOT_PP: begin
          // one block from each buffer, then stop
          if (st_reg.buffer_toggle_state) begin
            st_next.channel_on = 1'b0; // see RULE_16
          end
          st_next.buffer_toggle_state = ~st_reg.buffer_toggle_state; // see RULE_10
        end
        // continuous mode: block end leaves a same-cycle write alone
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{channel_on: 1'b0, dir: 1'b0, mode: MODE_CONT,
                  first_buffer_base: ADDR_RST, second_buffer_base: ADDR_RST,
                  periph_pointer: ADDR_RST, transfer_tally: TALLY_RST,
                  buffer_toggle_state: 1'b0};
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign cfg = st_reg;

endmodule // dcas_channel
`default_nettype wire

//--- verif/dcas_top_assertions.sv
// dcas_top_assertions: port-level checks of the dma address and status block.
// assumes it is bound to dcas_top and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module dcas_top_assertions import dcas_pkg::*; (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // engine side
  input wire logic xfer_done,
  input wire dcas_xfer_type xfer_info,
  input wire logic [NUM_CHAN-1:0] block_done,
  input wire logic [NUM_CHAN-1:0] periph_write_clash_evt,
  input wire logic [NUM_CHAN-1:0] ram_write_clash_evt,
  input wire dcas_chan_type [NUM_CHAN-1:0] chan_cfg,
  input wire logic [NUM_CHAN-1:0][15:0] current_buffer_base
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic req = avs_read || avs_write;
  wire logic done = ce && !avs_waitrequest;
  one_wait_a: assert property (req && avs_waitrequest && ce |=> !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  wait_pulse_a: assert property (done |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  status_zero_a: assert property (avs_read && done &&
    (avs_address == ADDR_CLASH || avs_address == ADDR_HISTORY) |->
    (avs_readdata & 32'hffff_f0f0) == 32'h0000_0000)
    else $error("unused status bits not zero");
  tally_load_a: assert property (avs_write && done && avs_address == 6'h04 &&
    avs_byteenable[1:0] == 2'b11 |=> chan_cfg[0].transfer_tally == $past(avs_writedata[9:0]))
    else $error("tally write lost");
  cfg_hold_a: assert property (!avs_write && block_done == 4'h0 |=> $stable(chan_cfg))
    else $error("channel settings moved without cause");
  oneshot_off_a: assert property (block_done[2] && ce && chan_cfg[2].channel_on &&
    chan_cfg[2].mode == MODE_ONESHOT |=> !chan_cfg[2].channel_on)
    else $error("one-shot channel still on after block");
  pp_flip_a: assert property (block_done[0] && ce && chan_cfg[0].channel_on &&
    chan_cfg[0].mode == MODE_CONT_PP |=> $changed(chan_cfg[0].buffer_toggle_state))
    else $error("ping-pong toggle did not flip");
  off_hold_a: assert property (block_done[2] && !chan_cfg[2].channel_on |=>
    $stable(chan_cfg[2].buffer_toggle_state))
    else $error("disabled channel reacted to block end");
  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_pick
    base_pick_a: assert property (current_buffer_base[c] == (chan_cfg[c].buffer_toggle_state ?
      chan_cfg[c].second_buffer_base : chan_cfg[c].first_buffer_base))
      else $error("current buffer base does not follow toggle");
  end
endmodule // dcas_top_assertions
bind dcas_top dcas_top_assertions dcas_top_assertions_i (.*);
`default_nettype wire

//--- verif/dcas_engine_model.sv
// dcas_engine_model: transfer engine stand-in raising one-cycle event pulses.
// assumes one caller at a time; info is inverted when unqualified so stale data never passes.
`timescale 1ns/100ps
`default_nettype none
module dcas_engine_model import dcas_pkg::*; (
  // clock
  input wire logic core_clk,
  // events
  output logic xfer_done,
  output dcas_xfer_type xfer_info,
  output logic [NUM_CHAN-1:0] block_done,
  output logic [NUM_CHAN-1:0] periph_write_clash_evt,
  output logic [NUM_CHAN-1:0] ram_write_clash_evt
);
  initial begin
    xfer_done = 1'b0;
    xfer_info = '0;
    block_done = 4'h0;
    periph_write_clash_evt = 4'h0;
    ram_write_clash_evt = 4'h0;
  end
  task automatic fire(input logic x, input dcas_xfer_type i, input logic [3:0] b,
                      input logic [3:0] p, input logic [3:0] r);
    @(posedge core_clk);
    xfer_done <= x;
    xfer_info <= i;
    block_done <= b;
    periph_write_clash_evt <= p;
    ram_write_clash_evt <= r;
    @(posedge core_clk);
    xfer_done <= 1'b0;
    xfer_info <= ~i;
    block_done <= 4'h0;
    periph_write_clash_evt <= 4'h0;
    ram_write_clash_evt <= 4'h0;
  endtask
endmodule // dcas_engine_model
`default_nettype wire

//--- verif/test_dma_channel_address_status.sv
// test_dma_channel_address_status: self-checking bench for dcas_top.
// assumes the engine model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module test_dma_channel_address_status import dcas_pkg::*;;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic xfer_done;
  dcas_xfer_type xfer_info;
  logic [NUM_CHAN-1:0] block_done;
  logic [NUM_CHAN-1:0] periph_write_clash_evt;
  logic [NUM_CHAN-1:0] ram_write_clash_evt;
  dcas_chan_type [NUM_CHAN-1:0] chan_cfg;
  logic [NUM_CHAN-1:0][15:0] current_buffer_base;
  logic [DATA_W-1:0] q[$];
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 80;
  dcas_top dcas_top_i (.*);
  dcas_engine_model dcas_engine_model_i (.*);
  initial forever #50 core_clk = ~core_clk;
  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // result watcher: read data stands at the edge where waitrequest is low
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (avs_read && avs_waitrequest === 1'b0) chk(q.pop_front(), avs_readdata);
    if (cyc == 20000) begin
      failures++;
      stop_test;
    end
  end
  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n == 20) failures++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    q.push_back({16'h0000, e});
    bus(1'b0, a, 16'h0000, 4'hf);
  endtask
  initial begin
    logic [15:0] r;
    logic [5:0] a;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 5; k++) rd(ADDR_W'(c * 8 + k), 16'h0000);
    end
    rd(ADDR_CLASH, 16'h0000);
    rd(ADDR_HISTORY, 16'h0f00);
    rd(ADDR_LATEST, 16'h0000);
    $display("test reset values done");
    // channels stay off while pointer and tally change
    for (int c = 0; c < 4; c++) begin
      for (int k = 1; k < 5; k++) begin
        a = ADDR_W'(c * 8 + k);
        r = 16'($random(seed));
        bus(1'b1, a, r, 4'h3);
        rd(a, k == 4 ? r & 16'h03ff : r);
      end
    end
    bus(1'b1, 6'h01, 16'haaaa, 4'h3);
    bus(1'b1, 6'h01, 16'h5555, 4'h2);
    rd(6'h01, 16'h55aa);
    bus(1'b1, 6'h05, 16'hffff, 4'h3);
    rd(6'h05, 16'h0000);
    rd(6'h23, 16'h0000);
    bus(1'b1, ADDR_LATEST, 16'hffff, 4'h3);
    rd(ADDR_LATEST, 16'h0000);
    $display("test registers done");
    bus(1'b1, 6'h08, 16'h8000, 4'h3);
    r = 16'($random(seed));
    dcas_engine_model_i.fire(1'b1, {2'd1, r}, 4'h0, 4'h0, 4'h0);
    rd(ADDR_HISTORY, 16'h0100);
    rd(ADDR_LATEST, r);
    dcas_engine_model_i.fire(1'b1, {2'd2, ~r}, 4'h0, 4'h0, 4'h0);
    rd(ADDR_HISTORY, 16'h0100);
    rd(ADDR_LATEST, r);
    $display("test transfers done");
    dcas_engine_model_i.fire(1'b0, '0, 4'h0, 4'h5, 4'ha);
    rd(ADDR_CLASH, 16'h050a);
    bus(1'b1, ADDR_CLASH, 16'hffff, 4'h3);
    rd(ADDR_CLASH, 16'h050a);
    bus(1'b1, ADDR_CLASH, 16'h0000, 4'h1);
    rd(ADDR_CLASH, 16'h0500);
    bus(1'b1, ADDR_CLASH, 16'h0000, 4'h3);
    rd(ADDR_CLASH, 16'h0000);
    $display("test clash flags done");
    bus(1'b1, 6'h01, 16'h1111, 4'h3);
    bus(1'b1, 6'h02, 16'h2222, 4'h3);
    chk(32'h0000_1111, {16'h0000, current_buffer_base[0]});
    bus(1'b1, 6'h00, 16'h8002, 4'h3);
    bus(1'b1, 6'h10, 16'h8001, 4'h3);
    bus(1'b1, 6'h18, 16'h8003, 4'h3);
    dcas_engine_model_i.fire(1'b0, '0, 4'hf, 4'h0, 4'h0);
    rd(ADDR_HISTORY, 16'h0109);
    rd(6'h10, 16'h0001);
    chk(32'h0000_2222, {16'h0000, current_buffer_base[0]});
    dcas_engine_model_i.fire(1'b0, '0, 4'hf, 4'h0, 4'h0);
    rd(ADDR_HISTORY, 16'h0100);
    rd(6'h18, 16'h0003);
    rd(6'h00, 16'h8002);
    chk(32'h0000_1111, {16'h0000, current_buffer_base[0]});
    // unused control bits must read zero even when written with ones
    bus(1'b1, 6'h08, 16'hffff, 4'h3);
    rd(6'h08, 16'ha003);
    $display("test modes done");
    // events that fall while the clock enable is low must be lost
    @(posedge core_clk);
    ce <= 1'b0;
    dcas_engine_model_i.fire(1'b0, '0, 4'h0, 4'h3, 4'h3);
    ce <= 1'b1;
    rd(ADDR_CLASH, 16'h0000);
    $display("test clock enable done");
    @(posedge core_clk);
    stop_test;
  end
endmodule // test_dma_channel_address_status
`default_nettype wire
